// >>> core/three_phase_sync_pwm_timer.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module three_phase_sync_pwm_timer (
	// clock and reset
	input  wire logic                          clock,
	input  wire logic                          resetn,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// count sources
	input  wire logic                          oscTick,
	input  wire logic                          extCountClockPin,
	// pwm pins
	output pwm_timer_pkg::pwm_pins_t           pwmPins,
	output logic      [6:0]                    pwmOe,
	output logic                               threeChannelPwmActive
);
	logic [1:0]  resetSync;
	logic        rstn;
	logic        run0, run1, stopSel0, stopSel1, trioBit, extPrev, togglePin;
	logic        next_run0, next_run1, next_stopSel0, next_stopSel1, next_trioBit, next_extPrev, next_togglePin;
	logic [1:0]  cmd, next_cmd;
	logic [3:0]  bufEn, next_bufEn;
	logic [4:0]  ctrl0, ctrl1, next_ctrl0, next_ctrl1;
	logic [4:0]  flag0, seen0, next_flag0, next_seen0, set0, clr0;
	logic [5:0]  flag1, seen1, next_flag1, next_seen1, set1, clr1;
	logic [15:0] cnt0, cnt1, next_cnt0, next_cnt1, cntCh1;
	logic [15:0] cmp0 [0:3];
	logic [15:0] cmp1 [0:3];
	logic [15:0] next_cmp0 [0:3];
	logic [15:0] next_cmp1 [0:3];
	logic [15:0] chg [0:2];
	logic [4:0]  prescale, next_prescale;
	logic [2:0]  normal, counterPh, next_normal, next_counterPh;
	logic [31:0] next_prdata;
	pwm_timer_pkg::dir_t dir, next_dir;
	logic        rsyncMode, cmplMode, running, tick, wr, rd;

	// address decode used only by the error answer; the read mux decodes with its own case
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= pwm_timer_pkg::OFF_CMP1 + pwm_timer_pkg::REG_STRIDE * 8'h03) && (a[1:0] == 2'h0);
	endfunction : mapped

	// count source tick from prescaler, oscillator or external pin edge
	function automatic logic countTick(input logic [4:0] ctrl, input logic [4:0] pre, input logic osc,
		input logic pin, input logic prev);
		logic [1:0] edg;
		edg = ctrl[pwm_timer_pkg::CTRL_EDG_HI:pwm_timer_pkg::CTRL_EDG_LO];
		case (ctrl[pwm_timer_pkg::CTRL_CKS_HI:pwm_timer_pkg::CTRL_CKS_LO])
			pwm_timer_pkg::CKS_F1:  countTick = 1'b1;
			pwm_timer_pkg::CKS_F2:  countTick = &pre[0:0];
			pwm_timer_pkg::CKS_F4:  countTick = &pre[1:0];
			pwm_timer_pkg::CKS_F8:  countTick = &pre[2:0];
			pwm_timer_pkg::CKS_F32: countTick = &pre[4:0];
			pwm_timer_pkg::CKS_OSC: countTick = osc;
			pwm_timer_pkg::CKS_EXT: begin
				if (edg == pwm_timer_pkg::EDGE_RISE)
					countTick = pin & ~prev;
				else if (edg == pwm_timer_pkg::EDGE_FALL)
					countTick = ~pin & prev;
				else
					countTick = pin ^ prev;
			end
			default: countTick = 1'b0;
		endcase
	endfunction : countTick

	// reset release through two flip-flops
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			resetSync <= 2'h0;
		else
			resetSync <= {resetSync[0], 1'b1};
	end
	assign rstn = resetSync[1];

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);
	assign pwmPins = '{toggle: togglePin, normal: normal, counter: counterPh};
	assign pwmOe   = {7{cmd != pwm_timer_pkg::CMD_NORMAL}};
	assign threeChannelPwmActive = trioBit & (cmd == pwm_timer_pkg::CMD_NORMAL);

	// next-state logic for counters, pins, flags and registers
	always_comb begin
		next_run0      = run0;
		next_run1      = run1;
		next_stopSel0  = stopSel0;
		next_stopSel1  = stopSel1;
		next_trioBit   = trioBit;
		next_cmd       = cmd;
		next_bufEn     = bufEn;
		next_ctrl0     = ctrl0;
		next_ctrl1     = ctrl1;
		next_cnt0      = cnt0;
		next_cnt1      = cnt1;
		next_dir       = dir;
		next_normal    = normal;
		next_counterPh = counterPh;
		next_togglePin = togglePin;
		next_seen0     = seen0;
		next_seen1     = seen1;
		next_prdata    = prdata;
		next_prescale  = prescale + 5'h01;
		next_extPrev   = extCountClockPin;
		for (int i = 0; i < 4; i++) begin
			next_cmp0[i] = cmp0[i];
			next_cmp1[i] = cmp1[i];
		end
		chg[0] = cmp0[pwm_timer_pkg::CMP_B];
		chg[1] = cmp1[pwm_timer_pkg::CMP_A];
		chg[2] = cmp1[pwm_timer_pkg::CMP_B];
		set0 = '0;
		set1 = '0;
		clr0 = '0;
		clr1 = '0;
		rsyncMode = (cmd == pwm_timer_pkg::CMD_RSYNC);
		cmplMode  = cmd[pwm_timer_pkg::MODE_CMD_HI];
		running   = rsyncMode ? run0 : (cmplMode & run0 & run1);
		// both counters share channel 0 source; channel 1 control is not consulted
		tick   = countTick(ctrl0, prescale, oscTick, extCountClockPin, extPrev);
		cntCh1 = rsyncMode ? cnt0 : cnt1;
		wr = psel & penable & pwrite;
		rd = psel & penable & ~pwrite;

		if (running && tick) begin
			// match flags, C and D included in buffer role
			for (int i = 0; i < 4; i++) begin
				if (cnt0 == cmp0[i])
					set0[i] = 1'b1;
				if (cntCh1 == cmp1[i])
					set1[i] = 1'b1;
			end
			if (rsyncMode) begin
				// pins come only from compare logic, io and polarity settings unused
				if (cnt0 == cmp0[pwm_timer_pkg::CMP_A]) begin
					next_cnt0      = pwm_timer_pkg::CNT_ZERO;
					next_togglePin = ~togglePin;
					next_normal    = 3'h7;
					next_counterPh = 3'h0;
					if (!stopSel0)
						next_run0 = 1'b0;
					// buffer transfer at period boundary
					if (bufEn[pwm_timer_pkg::BF_C0])
						next_cmp0[pwm_timer_pkg::CMP_A] = cmp0[pwm_timer_pkg::CMP_C];
					if (bufEn[pwm_timer_pkg::BF_D0])
						next_cmp0[pwm_timer_pkg::CMP_B] = cmp0[pwm_timer_pkg::CMP_D];
					if (bufEn[pwm_timer_pkg::BF_C1])
						next_cmp1[pwm_timer_pkg::CMP_A] = cmp1[pwm_timer_pkg::CMP_C];
					if (bufEn[pwm_timer_pkg::BF_D1])
						next_cmp1[pwm_timer_pkg::CMP_B] = cmp1[pwm_timer_pkg::CMP_D];
				end else begin
					next_cnt0 = cnt0 + pwm_timer_pkg::CNT_ONE;
					if (cnt0 == pwm_timer_pkg::CNT_MAX)
						set0[pwm_timer_pkg::FLAG_OVF] = 1'b1;
					for (int k = 0; k < 3; k++) begin
						if (cnt0 == chg[k]) begin
							next_normal[k]    = 1'b0;
							next_counterPh[k] = 1'b1;
						end
					end
				end
			end else begin
				case (dir)
					pwm_timer_pkg::DIR_UP: begin
						next_cnt0 = cnt0 + pwm_timer_pkg::CNT_ONE;
						next_cnt1 = cnt1 + pwm_timer_pkg::CNT_ONE;
						if (cnt0 == cmp0[pwm_timer_pkg::CMP_A]) begin
							next_dir       = pwm_timer_pkg::DIR_DOWN;
							next_togglePin = ~togglePin;
							if (!stopSel0)
								next_run0 = 1'b0;
						end
					end
					pwm_timer_pkg::DIR_DOWN: begin
						next_cnt0 = cnt0 - pwm_timer_pkg::CNT_ONE;
						next_cnt1 = cnt1 - pwm_timer_pkg::CNT_ONE;
						if (cnt1 == pwm_timer_pkg::CNT_ZERO) begin
							next_dir       = pwm_timer_pkg::DIR_UP;
							next_togglePin = ~togglePin;
							set1[pwm_timer_pkg::FLAG_UDF] = 1'b1;
							// change points reload at the trough; period never reloads
							if (bufEn[pwm_timer_pkg::BF_D0])
								next_cmp0[pwm_timer_pkg::CMP_B] = cmp0[pwm_timer_pkg::CMP_D];
							if (bufEn[pwm_timer_pkg::BF_C1])
								next_cmp1[pwm_timer_pkg::CMP_A] = cmp1[pwm_timer_pkg::CMP_C];
							if (bufEn[pwm_timer_pkg::BF_D1])
								next_cmp1[pwm_timer_pkg::CMP_B] = cmp1[pwm_timer_pkg::CMP_D];
						end
					end
					default: next_dir = pwm_timer_pkg::DIR_UP;
				endcase
				if (cnt1 == cmp1[pwm_timer_pkg::CMP_A] && !stopSel1)
					next_run1 = 1'b0;
				// phases from counter position and direction; gap between them is dead time
				for (int k = 0; k < 3; k++) begin
					if (dir == pwm_timer_pkg::DIR_UP) begin
						next_normal[k]    = (cnt1 != pwm_timer_pkg::CNT_MAX) && (cnt1 > chg[k]);
						next_counterPh[k] = (cnt0 < chg[k]);
					end else begin
						next_normal[k]    = (cnt1 >= chg[k]);
						next_counterPh[k] = (cnt0 <= chg[k]);
					end
				end
			end
		end

		// register writes
		if (wr) begin
			case (paddr)
				pwm_timer_pkg::OFF_START: begin
					next_run0     = pwdata[pwm_timer_pkg::START_RUN0];
					next_run1     = pwdata[pwm_timer_pkg::START_RUN1];
					next_stopSel0 = pwdata[pwm_timer_pkg::START_SEL0];
					next_stopSel1 = pwdata[pwm_timer_pkg::START_SEL1];
				end
				pwm_timer_pkg::OFF_MODE: begin
					next_cmd   = pwdata[pwm_timer_pkg::MODE_CMD_HI:pwm_timer_pkg::MODE_CMD_LO];
					next_bufEn = pwdata[pwm_timer_pkg::MODE_BF_HI:pwm_timer_pkg::MODE_BF_LO];
				end
				pwm_timer_pkg::OFF_FUNC:  next_trioBit = pwdata[pwm_timer_pkg::FUNC_TRIO];
				pwm_timer_pkg::OFF_CTRL0: next_ctrl0 = pwdata[pwm_timer_pkg::CTRL_W-1:0];
				pwm_timer_pkg::OFF_CTRL1: next_ctrl1 = pwdata[pwm_timer_pkg::CTRL_W-1:0];
				pwm_timer_pkg::OFF_STAT0: begin
					clr0       = ~pwdata[pwm_timer_pkg::FLAG0_W-1:0] & seen0;
					next_seen0 = '0;
				end
				pwm_timer_pkg::OFF_STAT1: begin
					clr1       = ~pwdata[pwm_timer_pkg::FLAG1_W-1:0] & seen1;
					next_seen1 = '0;
				end
				pwm_timer_pkg::OFF_CNT0: next_cnt0 = pwdata[pwm_timer_pkg::CNT_W-1:0];
				pwm_timer_pkg::OFF_CNT1: next_cnt1 = pwdata[pwm_timer_pkg::CNT_W-1:0];
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (paddr == pwm_timer_pkg::OFF_CMP0 + pwm_timer_pkg::REG_STRIDE * 8'(i))
							if (!(cmplMode && running && i == pwm_timer_pkg::CMP_A))
								next_cmp0[i] = pwdata[pwm_timer_pkg::CNT_W-1:0];
						if (paddr == pwm_timer_pkg::OFF_CMP1 + pwm_timer_pkg::REG_STRIDE * 8'(i))
							next_cmp1[i] = pwdata[pwm_timer_pkg::CNT_W-1:0];
					end
				end
			endcase
		end

		// a flag is armed for clearing only by a read that saw it set
		if (rd && paddr == pwm_timer_pkg::OFF_STAT0)
			next_seen0 = prdata[pwm_timer_pkg::FLAG0_W-1:0];
		if (rd && paddr == pwm_timer_pkg::OFF_STAT1)
			next_seen1 = prdata[pwm_timer_pkg::FLAG1_W-1:0];
		next_flag0 = (flag0 & ~clr0) | set0;
		next_flag1 = (flag1 & ~clr1) | set1;

		// read data captured in the setup cycle
		if (psel && !penable && !pwrite) begin
			next_prdata = 32'h0000_0000;
			case (paddr)
				pwm_timer_pkg::OFF_START: next_prdata[3:0] = {stopSel1, stopSel0, run1, run0};
				pwm_timer_pkg::OFF_MODE: begin
					next_prdata[pwm_timer_pkg::MODE_CMD_HI:pwm_timer_pkg::MODE_CMD_LO] = cmd;
					next_prdata[pwm_timer_pkg::MODE_BF_HI:pwm_timer_pkg::MODE_BF_LO]   = bufEn;
				end
				pwm_timer_pkg::OFF_FUNC:  next_prdata[pwm_timer_pkg::FUNC_TRIO] = trioBit;
				pwm_timer_pkg::OFF_CTRL0: next_prdata[pwm_timer_pkg::CTRL_W-1:0] = ctrl0;
				pwm_timer_pkg::OFF_CTRL1: next_prdata[pwm_timer_pkg::CTRL_W-1:0] = ctrl1;
				pwm_timer_pkg::OFF_STAT0: begin
					next_prdata[pwm_timer_pkg::FLAG0_W-1:0] = flag0;
					next_prdata[pwm_timer_pkg::STAT_B5]     = 1'b1;
				end
				pwm_timer_pkg::OFF_STAT1: next_prdata[pwm_timer_pkg::FLAG1_W-1:0] = flag1;
				pwm_timer_pkg::OFF_CNT0:  next_prdata[pwm_timer_pkg::CNT_W-1:0] = cnt0;
				pwm_timer_pkg::OFF_CNT1:  next_prdata[pwm_timer_pkg::CNT_W-1:0] = cnt1;
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (paddr == pwm_timer_pkg::OFF_CMP0 + pwm_timer_pkg::REG_STRIDE * 8'(i))
							next_prdata[pwm_timer_pkg::CNT_W-1:0] = cmp0[i];
						if (paddr == pwm_timer_pkg::OFF_CMP1 + pwm_timer_pkg::REG_STRIDE * 8'(i))
							next_prdata[pwm_timer_pkg::CNT_W-1:0] = cmp1[i];
					end
				end
			endcase
		end
	end

	// state registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			run0      <= 1'b0;
			run1      <= 1'b0;
			stopSel0  <= 1'b0;
			stopSel1  <= 1'b0;
			trioBit   <= 1'b0;
			cmd       <= pwm_timer_pkg::CMD_NORMAL;
			bufEn     <= 4'h0;
			ctrl0     <= 5'h00;
			ctrl1     <= 5'h00;
			flag0     <= 5'h00;
			flag1     <= 6'h00;
			seen0     <= 5'h00;
			seen1     <= 6'h00;
			cnt0      <= pwm_timer_pkg::CNT_ZERO;
			cnt1      <= pwm_timer_pkg::CNT_ZERO;
			dir       <= pwm_timer_pkg::DIR_UP;
			prescale  <= 5'h00;
			extPrev   <= 1'b0;
			normal    <= 3'h0;
			counterPh <= 3'h0;
			togglePin <= 1'b0;
			prdata    <= 32'h0000_0000;
			for (int i = 0; i < 4; i++) begin
				cmp0[i] <= pwm_timer_pkg::CNT_MAX;
				cmp1[i] <= pwm_timer_pkg::CNT_MAX;
			end
		end else begin
			run0      <= next_run0;
			run1      <= next_run1;
			stopSel0  <= next_stopSel0;
			stopSel1  <= next_stopSel1;
			trioBit   <= next_trioBit;
			cmd       <= next_cmd;
			bufEn     <= next_bufEn;
			ctrl0     <= next_ctrl0;
			ctrl1     <= next_ctrl1;
			flag0     <= next_flag0;
			flag1     <= next_flag1;
			seen0     <= next_seen0;
			seen1     <= next_seen1;
			cnt0      <= next_cnt0;
			cnt1      <= next_cnt1;
			dir       <= next_dir;
			prescale  <= next_prescale;
			extPrev   <= next_extPrev;
			normal    <= next_normal;
			counterPh <= next_counterPh;
			togglePin <= next_togglePin;
			prdata    <= next_prdata;
			for (int i = 0; i < 4; i++) begin
				cmp0[i] <= next_cmp0[i];
				cmp1[i] <= next_cmp1[i];
			end
		end
	end
endmodule : three_phase_sync_pwm_timer

// >>> core/pwm_timer_pkg.sv
package pwm_timer_pkg;
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam int          CNT_W       = 16;
	localparam int          PRESCALE_W  = 5;
	// register byte offsets
	localparam logic [7:0]  OFF_START   = 8'h00;
	localparam logic [7:0]  OFF_MODE    = 8'h04;
	localparam logic [7:0]  OFF_FUNC    = 8'h08;
	localparam logic [7:0]  OFF_CTRL0   = 8'h0C;
	localparam logic [7:0]  OFF_CTRL1   = 8'h10;
	localparam logic [7:0]  OFF_STAT0   = 8'h14;
	localparam logic [7:0]  OFF_STAT1   = 8'h18;
	localparam logic [7:0]  OFF_CNT0    = 8'h1C;
	localparam logic [7:0]  OFF_CNT1    = 8'h20;
	localparam logic [7:0]  OFF_CMP0    = 8'h24;
	localparam logic [7:0]  OFF_CMP1    = 8'h34;
	localparam logic [7:0]  REG_STRIDE  = 8'h04;
	// start register fields
	localparam int          START_RUN0  = 0;
	localparam int          START_RUN1  = 1;
	localparam int          START_SEL0  = 2;
	localparam int          START_SEL1  = 3;
	// mode register fields
	localparam int          MODE_CMD_LO = 0;
	localparam int          MODE_CMD_HI = 1;
	localparam int          MODE_BF_LO  = 4;
	localparam int          MODE_BF_HI  = 7;
	localparam int          FUNC_TRIO   = 0;
	// control register fields
	localparam int          CTRL_CKS_LO = 0;
	localparam int          CTRL_CKS_HI = 2;
	localparam int          CTRL_EDG_LO = 3;
	localparam int          CTRL_EDG_HI = 4;
	localparam int          CTRL_W      = 5;
	// status flags
	localparam int          FLAG0_W     = 5;
	localparam int          FLAG1_W     = 6;
	localparam int          FLAG_OVF    = 4;
	localparam int          FLAG_UDF    = 5;
	localparam int          STAT_B5     = 5;
	// compare register indices, buffer enable indices
	localparam int          CMP_A       = 0;
	localparam int          CMP_B       = 1;
	localparam int          CMP_C       = 2;
	localparam int          CMP_D       = 3;
	localparam int          BF_C0       = 0;
	localparam int          BF_D0       = 1;
	localparam int          BF_C1       = 2;
	localparam int          BF_D1       = 3;
	// combined modes
	localparam logic [1:0]  CMD_NORMAL  = 2'h0;
	localparam logic [1:0]  CMD_RSYNC   = 2'h1;
	// count source selections
	localparam logic [2:0]  CKS_F1      = 3'h0;
	localparam logic [2:0]  CKS_F2      = 3'h1;
	localparam logic [2:0]  CKS_F4      = 3'h2;
	localparam logic [2:0]  CKS_F8      = 3'h3;
	localparam logic [2:0]  CKS_F32     = 3'h4;
	localparam logic [2:0]  CKS_EXT     = 3'h5;
	localparam logic [2:0]  CKS_OSC     = 3'h6;
	localparam logic [1:0]  EDGE_RISE   = 2'h0;
	localparam logic [1:0]  EDGE_FALL   = 2'h1;
	localparam logic [15:0] CNT_ZERO    = 16'h0000;
	localparam logic [15:0] CNT_ONE     = 16'h0001;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;

	typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_t;

	// toggle = pin_c_chan0; normal = pin_b_chan0, pin_a_chan1, pin_b_chan1;
	// counter = pin_d_chan0, pin_c_chan1, pin_d_chan1
	typedef struct packed {
		logic       toggle;
		logic [2:0] normal;
		logic [2:0] counter;
	} pwm_pins_t;
endpackage : pwm_timer_pkg

// >>> test/pwm_timer_assertions.sv
`timescale 1ns/1ps
module pwm_timer_assertions (
	// clock and reset
	input wire logic                     clock,
	input wire logic                     resetn,
	// apb slave side
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [7:0]               paddr,
	input wire logic [31:0]              pwdata,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	// pins
	input wire pwm_timer_pkg::pwm_pins_t pwmPins,
	input wire logic [6:0]               pwmOe,
	input wire logic                     threeChannelPwmActive
);
	logic       wr;
	logic [1:0] modeSeen;
	logic       stopped;
	// a write completes in the access phase
	assign wr = psel && penable && pwrite;
	// shadow of the combined mode field and of a stop request
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			modeSeen <= 2'h0;
			stopped  <= 1'b1;
		end else begin
			if (wr && paddr == pwm_timer_pkg::OFF_MODE)
				modeSeen <= pwdata[1:0];
			if (wr && paddr == pwm_timer_pkg::OFF_START)
				stopped <= (pwdata[1:0] == 2'h0);
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence statRead;
		psel && penable && !pwrite && paddr == pwm_timer_pkg::OFF_STAT0;
	endsequence
	sequence periodStart;
		$changed(pwmPins.toggle) && modeSeen == pwm_timer_pkg::CMD_RSYNC;
	endsequence
	ready_always_a: assert property (pready)
		else $error("pready low");
	bus_error_a: assert property (psel && penable |-> pslverr == (paddr > 8'h40 || paddr[1:0] != 2'h0))
		else $error("pslverr does not match address");
	status_bit5_a: assert property (statRead |-> prdata[5])
		else $error("status bit 5 read as zero");
	mode_oe_a: assert property (pwmOe == {7{modeSeen != pwm_timer_pkg::CMD_NORMAL}})
		else $error("output enables do not follow mode");
	mode_exclusive_a: assert property (threeChannelPwmActive |-> modeSeen == pwm_timer_pkg::CMD_NORMAL)
		else $error("three channel bit active in combined mode");
	no_overlap_a: assert property ((pwmPins.normal & pwmPins.counter) == 3'h0)
		else $error("normal and counter phase both active");
	rsync_toggle_a: assert property (periodStart |-> &pwmPins.normal)
		else $error("toggle flipped away from period start");
	stop_hold_a: assert property (stopped && !wr |=> $stable(pwmPins))
		else $error("pins moved while stopped");
endmodule : pwm_timer_assertions

bind three_phase_sync_pwm_timer pwm_timer_assertions pwm_timer_assertions_i (
	.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwmPins(pwmPins),
	.pwmOe(pwmOe), .threeChannelPwmActive(threeChannelPwmActive)
);

// >>> test/gate_driver_model.sv
`timescale 1ns/1ps
module gate_driver_model (
	// clock
	input  wire logic                     clock,
	// gate inputs and their enables
	input  wire pwm_timer_pkg::pwm_pins_t pwmPins,
	input  wire logic [6:0]               pwmOe,
	// last high widths and toggle interval, in clocks
	output int                            highNormal [3],
	output int                            highCounter [3],
	output int                            toggleGap,
	output int                            toggles
);
	int   runN [3];
	int   runC [3];
	int   gap;
	logic lastToggle;
	// a gate counts only while enabled; width latches when it goes inactive
	always @(posedge clock) begin
		for (int k = 0; k < 3; k++) begin
			runN[k] <= (pwmPins.normal[k] && |pwmOe) ? runN[k] + 1 : 0;
			runC[k] <= (pwmPins.counter[k] && |pwmOe) ? runC[k] + 1 : 0;
			if (!pwmPins.normal[k] && runN[k] != 0)
				highNormal[k] <= runN[k];
			if (!pwmPins.counter[k] && runC[k] != 0)
				highCounter[k] <= runC[k];
		end
		lastToggle <= pwmPins.toggle;
		gap        <= (pwmPins.toggle != lastToggle) ? 1 : gap + 1;
		if (pwmPins.toggle != lastToggle) begin
			toggleGap <= gap;
			toggles   <= toggles + 1;
		end
	end
	// quiet gates at power up
	initial begin
		runN        = '{0, 0, 0};
		runC        = '{0, 0, 0};
		highNormal  = '{0, 0, 0};
		highCounter = '{0, 0, 0};
		gap         = 0;
		toggleGap   = 0;
		toggles     = 0;
		lastToggle  = 1'b0;
	end
endmodule : gate_driver_model

// >>> test/three_phase_sync_pwm_timer_tb.sv
`timescale 1ns/1ps
module three_phase_sync_pwm_timer_tb;
	logic                     clock, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic                     oscTick, extCountClockPin, threeChannelPwmActive;
	logic [7:0]               paddr;
	logic [31:0]              pwdata, prdata, rd;
	logic [6:0]               pwmOe;
	pwm_timer_pkg::pwm_pins_t pwmPins, held;
	int                       highNormal [3], highCounter [3];
	int                       toggleGap, toggles, phase, nMismatch, samplesChecked;

	three_phase_sync_pwm_timer three_phase_sync_pwm_timer_i (
		.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.oscTick(oscTick), .extCountClockPin(extCountClockPin), .pwmPins(pwmPins), .pwmOe(pwmOe),
		.threeChannelPwmActive(threeChannelPwmActive)
	);
	gate_driver_model gate_driver_model_i (
		.clock(clock), .pwmPins(pwmPins), .pwmOe(pwmOe), .highNormal(highNormal),
		.highCounter(highCounter), .toggleGap(toggleGap), .toggles(toggles)
	);
	// clock; oscillator tick every 4th clock, external pin period of 6 clocks
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		phase            <= phase + 1;
		oscTick          <= (phase % 4) == 3;
		extCountClockPin <= (phase % 6) < 3;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		// no wait-state limit here: only the watchdog ends a stuck transfer
		while (pready !== 1'b1)
			@(posedge clock);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task waitToggles(input int n);
		int t0;
		t0 = toggles;
		for (int i = 0; i < 4000 && toggles < t0 + n; i++)
			@(posedge clock);
		// toggle pin that never flips counts as a failure
		if (toggles < t0 + n)
			nMismatch++;
	endtask : waitToggles
	task regDefaults;
		apb(1'b0, pwm_timer_pkg::OFF_CMP0, 32'h0);
		check(rd, 32'h0000FFFF);
		apb(1'b0, pwm_timer_pkg::OFF_STAT0, 32'h0);
		check(rd, 32'h00000020);
		apb(1'b1, 8'h44, 32'h1);
		check({31'h0, err}, 32'h1);
		apb(1'b0, 8'h44, 32'h0);
		check(rd, 32'h0);
	endtask : regDefaults
	task modeSelect;
		apb(1'b1, pwm_timer_pkg::OFF_FUNC, 32'h1);
		@(negedge clock);
		check({31'h0, threeChannelPwmActive}, 32'h1);
		for (int m = 1; m < 4; m++) begin
			apb(1'b1, pwm_timer_pkg::OFF_MODE, 32'(m));
			@(negedge clock);
			check({31'h0, threeChannelPwmActive}, 32'h0);
			check({25'h0, pwmOe}, 32'h7F);
		end
		apb(1'b1, pwm_timer_pkg::OFF_FUNC, 32'h0);
	endtask : modeSelect
	// each count source, measured by the reset synchronous period
	task countSources;
		logic [31:0] ctrl [9] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h6, 32'h5, 32'hD, 32'h15};
		int          div  [9] = '{1, 2, 4, 8, 32, 4, 6, 6, 3};
		apb(1'b1, pwm_timer_pkg::OFF_MODE, 32'h1);
		apb(1'b1, pwm_timer_pkg::OFF_CMP0, 32'h9);
		apb(1'b1, pwm_timer_pkg::OFF_CTRL1, 32'h7);
		for (int s = 0; s < 9; s++) begin
			apb(1'b1, pwm_timer_pkg::OFF_CTRL0, ctrl[s]);
			apb(1'b1, pwm_timer_pkg::OFF_START, 32'h5);
			waitToggles(3);
			check(toggleGap, 32'(10 * div[s]));
			apb(1'b1, pwm_timer_pkg::OFF_START, 32'h4);
		end
	endtask : countSources
	// buffered change points, unused C1, flag clearing
	task syncPhases;
		int nrm [3] = '{6, 6, 8};
		apb(1'b1, pwm_timer_pkg::OFF_MODE, 32'h31);
		apb(1'b1, pwm_timer_pkg::OFF_CTRL0, 32'h0);
		apb(1'b1, pwm_timer_pkg::OFF_CMP0 + 8'h04, 32'h3);
		apb(1'b1, pwm_timer_pkg::OFF_CMP0 + 8'h08, 32'hB);
		apb(1'b1, pwm_timer_pkg::OFF_CMP0 + 8'h0C, 32'h5);
		apb(1'b1, pwm_timer_pkg::OFF_CMP1, 32'h5);
		apb(1'b1, pwm_timer_pkg::OFF_CMP1 + 8'h04, 32'h7);
		apb(1'b1, pwm_timer_pkg::OFF_CMP1 + 8'h08, 32'h2);
		apb(1'b1, pwm_timer_pkg::OFF_START, 32'h5);
		waitToggles(3);
		for (int k = 0; k < 3; k++) begin
			check(highNormal[k], 32'(nrm[k]));
			check(highCounter[k], 32'(12 - nrm[k]));
		end
		check(toggleGap, 32'hC);
		apb(1'b1, pwm_timer_pkg::OFF_START, 32'h4);
		apb(1'b0, pwm_timer_pkg::OFF_STAT0, 32'h0);
		check(rd & 32'h25, 32'h25);
		apb(1'b1, pwm_timer_pkg::OFF_STAT0, 32'h1F);
		apb(1'b1, pwm_timer_pkg::OFF_STAT0, 32'h0);
		apb(1'b0, pwm_timer_pkg::OFF_STAT0, 32'h0);
		check(rd & 32'h21, 32'h21);
		apb(1'b1, pwm_timer_pkg::OFF_STAT0, 32'h0);
		apb(1'b0, pwm_timer_pkg::OFF_STAT0, 32'h0);
		check(rd & 32'h21, 32'h20);
	endtask : syncPhases
	// triangular mode with m = 20, dead time p = 3, then stop
	task complementary;
		int nv [3] = '{8, 10, 12};
		apb(1'b1, pwm_timer_pkg::OFF_MODE, 32'h2);
		apb(1'b1, pwm_timer_pkg::OFF_CTRL1, 32'h0);
		apb(1'b1, pwm_timer_pkg::OFF_CMP0, 32'h14);
		apb(1'b1, pwm_timer_pkg::OFF_CMP0 + 8'h04, 32'h8);
		apb(1'b1, pwm_timer_pkg::OFF_CMP1, 32'hA);
		apb(1'b1, pwm_timer_pkg::OFF_CMP1 + 8'h04, 32'hC);
		apb(1'b1, pwm_timer_pkg::OFF_CNT0, 32'h3);
		apb(1'b1, pwm_timer_pkg::OFF_CNT1, 32'h0);
		apb(1'b1, pwm_timer_pkg::OFF_START, 32'hF);
		waitToggles(4);
		check(toggleGap, 32'(20 + 2 - 3));
		for (int k = 0; k < 3; k++) begin
			check(highNormal[k], 32'(2 * (20 - nv[k] - 3 + 1)));
			check(highCounter[k], 32'(2 * (nv[k] + 1 - 3)));
		end
		apb(1'b1, pwm_timer_pkg::OFF_CMP0, 32'h1E);
		apb(1'b0, pwm_timer_pkg::OFF_CMP0, 32'h0);
		check(rd, 32'h14);
		waitToggles(2);
		check(toggleGap, 32'(20 + 2 - 3));
		apb(1'b1, pwm_timer_pkg::OFF_START, 32'hC);
		@(negedge clock);
		held = pwmPins;
		repeat (40) @(posedge clock);
		check(32'(pwmPins), 32'(held));
		apb(1'b0, pwm_timer_pkg::OFF_STAT1, 32'h0);
		check(rd & 32'h20, 32'h20);
	endtask : complementary
	task testDone;
		$display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : testDone
	// main sequence
	initial begin
		resetn           = 1'b0;
		psel             = 1'b0;
		penable          = 1'b0;
		pwrite           = 1'b0;
		paddr            = 8'h00;
		pwdata           = 32'h0;
		oscTick          = 1'b0;
		extCountClockPin = 1'b0;
		phase            = 0;
		nMismatch        = 0;
		samplesChecked   = 0;
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		regDefaults;
		modeSelect;
		countSources;
		syncPhases;
		complementary;
		testDone;
	end
	// watchdog
	initial begin
		repeat (30000) @(posedge clock);
		nMismatch++;
		testDone;
	end
endmodule : three_phase_sync_pwm_timer_tb
